// file: rtl/timer_pkg.sv
// Shared constants and carrier types for the timer block
package timer_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_TB_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TB_LOW = 8'h08;
  localparam logic [7:0] ADDR_TB_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_TC_LOW = 8'h10;
  localparam logic [7:0] ADDR_TC_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CAP_LOW = 8'h18;
  localparam logic [7:0] ADDR_CAP_HIGH = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  localparam logic [7:0] ADDR_SERIAL_MODE = 8'h28;
  localparam logic [7:0] ADDR_T3_CTRL = 8'hc8;
  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int TB_GATE_BIT = 7;
  localparam int TB_CNT_SEL_BIT = 6;
  localparam int TB_RUN_BIT = 0;
  localparam int TB_FLAG_BIT = 1;
  localparam int T3_OVF_BIT = 7;
  localparam int T3_EXT_FLAG_BIT = 6;
  localparam int RX_BAUD_BIT = 5;
  localparam int TX_BAUD_BIT = 4;
  localparam int EXT_EN_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int CNT_SEL_BIT = 1;
  localparam int CAP_SEL_BIT = 0;
  localparam int IRQ_TB_BIT = 0;
  localparam int IRQ_TC_OVF_BIT = 1;
  localparam int IRQ_TC_EXT_BIT = 2;
  // Mode field codes of the second timer
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_HALT = 2'h3;
  // Last prescaler count of a machine cycle, which is 12 clocks long
  localparam logic [3:0] MC_LAST = 4'hb;
  // Synchronised pins: count input b, gate b, count input c, trigger c
  localparam int PIN_COUNT = 4;
  localparam int PIN_TB_COUNT = 0;
  localparam int PIN_TB_GATE = 1;
  localparam int PIN_TC_COUNT = 2;
  localparam int PIN_TC_TRIG = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane;
    logic [7:0] rd_addr;
  } reg_access_t;
  typedef struct packed {
    logic wr_hit;
    logic rd_hit;
    logic [7:0] rd_data;
  } reg_answer_t;
endpackage

// file: rtl/pin_sync_edge.sv
// Two-stage synchronisers and falling-edge detectors for the pins
`timescale 1ns/10ps
module pin_sync_edge (
  input wire logic clk, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [timer_pkg::PIN_COUNT-1:0] pins, // Raw pin levels
  output logic [timer_pkg::PIN_COUNT-1:0] level, // Synchronised levels
  output logic [timer_pkg::PIN_COUNT-1:0] fall // One-cycle falling pulses
);
  typedef struct packed {
    logic [timer_pkg::PIN_COUNT-1:0] meta;
    logic [timer_pkg::PIN_COUNT-1:0] sync;
    logic [timer_pkg::PIN_COUNT-1:0] last;
  } sync_state_t;
  sync_state_t r;
  sync_state_t next_r;
  // Only the second stage feeds logic; the first may be metastable
  always_comb begin
    next_r.meta = pins;
    next_r.sync = r.meta;
    next_r.last = r.sync;
  end
  // Pins idle high, so reset to ones to avoid a false edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end
  assign level = r.sync;
  genvar i;
  generate
    for (i = 0; i < timer_pkg::PIN_COUNT; i++) begin : g_edge
      assign fall[i] = r.last[i] & ~r.sync[i];
    end
  endgenerate
endmodule

// file: rtl/axil_slave.sv
// AXI4-Lite slave front end turning bus beats into register strobes
`timescale 1ns/10ps
module axil_slave (
  input wire logic clk, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [7:0] awaddr, // Write byte address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte lanes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [7:0] araddr, // Read byte address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output timer_pkg::reg_access_t acc, // Strobes to the register file
  input timer_pkg::reg_answer_t ans // Decode and read data back
);
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [7:0] r_data;
    logic [1:0] r_resp;
  } axil_state_t;
  axil_state_t r;
  axil_state_t next_r;
  logic fire;
  // Address and data latch independently; the write fires once both are held
  always_comb begin
    next_r = r;
    fire = r.aw_full & r.w_full & ~r.b_valid;
    if (awvalid & awready) begin
      next_r.aw_full = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid & wready) begin
      next_r.w_full = 1'b1;
      next_r.w_data = wdata[7:0];
      next_r.w_lane = wstrb[0];
    end
    if (fire) begin
      next_r.aw_full = 1'b0;
      next_r.w_full = 1'b0;
      next_r.b_valid = 1'b1;
      next_r.b_resp = ans.wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (r.b_valid & bready) begin
      next_r.b_valid = 1'b0;
    end
    if (arvalid & arready) begin
      next_r.r_valid = 1'b1;
      next_r.r_data = ans.rd_data;
      next_r.r_resp = ans.rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (r.r_valid & rready) begin
      next_r.r_valid = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // One write and one read in flight; a held response stalls new requests
  assign awready = ~r.aw_full & ~r.b_valid;
  assign wready = ~r.w_full & ~r.b_valid;
  assign arready = ~r.r_valid;
  assign bvalid = r.b_valid;
  assign bresp = r.b_resp;
  assign rvalid = r.r_valid;
  assign rdata = {24'h000000, r.r_data};
  assign rresp = r.r_resp;
  assign acc.wr = fire & ans.wr_hit;
  assign acc.wr_addr = r.aw_addr;
  assign acc.wr_data = r.w_data;
  assign acc.wr_lane = r.w_lane;
  assign acc.rd_addr = araddr;
endmodule

// file: rtl/timer_block.sv
// Second standard timer and 16-bit third timer with serial baud selection
`timescale 1ns/10ps
module timer_block (
  input wire logic REF_CLK, // System clock, 100 MHz
  input wire logic ARST_N, // Asynchronous reset, active low
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [7:0] S_AXI_AWADDR, // Write byte address
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Write byte lanes
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  output logic [1:0] S_AXI_BRESP, // Write response
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  input wire logic [7:0] S_AXI_ARADDR, // Read byte address
  output logic S_AXI_RVALID, // Read data valid
  input wire logic S_AXI_RREADY, // Read data ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  input wire logic TIMER_B_COUNT_PIN, // Event input of the second timer
  input wire logic TIMER_B_GATE_PIN, // Gate input of the second timer
  input wire logic TIMER_C_COUNT_PIN, // Event input of the third timer
  input wire logic TIMER_C_TRIGGER_PIN, // Capture/reload trigger
  output logic SERIAL_RX_TICK, // Receive clock pulse to serial port
  output logic SERIAL_TX_TICK, // Transmit clock pulse to serial port
  output logic IRQ // Level interrupt
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] presc;
    logic [7:0] timer_mode_register;
    logic timer_b_run;
    logic timer_b_overflow_flag;
    logic [7:0] timer_b_low_count;
    logic [7:0] timer_b_high_count;
    logic [7:0] timer_three_control;
    logic [7:0] timer_c_low_count;
    logic [7:0] timer_c_high_count;
    logic [7:0] capture_low_register;
    logic [7:0] capture_high_register;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [1:0] serial_mode;
    logic rx_tick;
    logic tx_tick;
  } timers_state_t;
  timers_state_t r;
  timers_state_t next_r;
  timer_pkg::reg_access_t acc;
  timer_pkg::reg_answer_t ans;
  logic [timer_pkg::PIN_COUNT-1:0] pin_level;
  logic [timer_pkg::PIN_COUNT-1:0] pin_fall;
  logic mc_tick, tb_split, tb_enable, tb_tick, tb_ovf;
  logic [1:0] tb_mode;
  logic [12:0] tb_13;
  logic tc_run, tc_baud, tc_capture, tc_tick, tc_ovf, trig_evt;
  logic [15:0] tc_count;
  logic [7:0] wd;
  logic we;
  logic [8:0] rd_word;
  logic [8:0] wr_word;
  // ----------------------------------------------------------------
  // Bus front end and pin synchronisers
  // ----------------------------------------------------------------
  axil_slave u_bus (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .awaddr(S_AXI_AWADDR),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .bresp(S_AXI_BRESP),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .araddr(S_AXI_ARADDR),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .acc(acc),
    .ans(ans)
  );
  pin_sync_edge u_pins (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .pins({TIMER_C_TRIGGER_PIN, TIMER_C_COUNT_PIN, TIMER_B_GATE_PIN, TIMER_B_COUNT_PIN}),
    .level(pin_level),
    .fall(pin_fall)
  );
  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  function automatic logic [8:0] read_reg(input timers_state_t s, input logic [7:0] a);
    logic [8:0] v;
    v = 9'h000;
    unique case (a)
      timer_pkg::ADDR_MODE: v = {1'b1, s.timer_mode_register};
      timer_pkg::ADDR_TB_CTRL: v = {7'h40, s.timer_b_overflow_flag, s.timer_b_run};
      timer_pkg::ADDR_TB_LOW: v = {1'b1, s.timer_b_low_count};
      timer_pkg::ADDR_TB_HIGH: v = {1'b1, s.timer_b_high_count};
      timer_pkg::ADDR_TC_LOW: v = {1'b1, s.timer_c_low_count};
      timer_pkg::ADDR_TC_HIGH: v = {1'b1, s.timer_c_high_count};
      timer_pkg::ADDR_CAP_LOW: v = {1'b1, s.capture_low_register};
      timer_pkg::ADDR_CAP_HIGH: v = {1'b1, s.capture_high_register};
      timer_pkg::ADDR_IRQ_STATUS: v = {6'h20, s.irq_status};
      timer_pkg::ADDR_IRQ_MASK: v = {6'h20, s.irq_mask};
      timer_pkg::ADDR_SERIAL_MODE: v = {7'h40, s.serial_mode};
      timer_pkg::ADDR_T3_CTRL: v = {1'b1, s.timer_three_control};
      default: v = 9'h000;
    endcase
    return v;
  endfunction
  // Unmapped addresses answer with a slave error and read as zero
  always_comb begin
    rd_word = read_reg(r, acc.rd_addr);
    wr_word = read_reg(r, acc.wr_addr);
    // Bit 8 of a decoded word marks a mapped register
    ans.rd_hit = rd_word[8];
    ans.rd_data = rd_word[7:0];
    ans.wr_hit = wr_word[8];
  end
  // ----------------------------------------------------------------
  // Timer datapath
  // ----------------------------------------------------------------
  // Counts and fields are written last, so a software write wins over
  // counting; flags are OR-ed in after the write so a hardware set wins.
  always_comb begin
    next_r = r;
    wd = acc.wr_data;
    we = acc.wr & acc.wr_lane;
    mc_tick = (r.presc == timer_pkg::MC_LAST);
    next_r.presc = mc_tick ? 4'h0 : r.presc + 4'h1;
    // Second timer enable; a split first timer owns its run bit
    tb_mode = r.timer_mode_register[5:4];
    tb_split = (r.timer_mode_register[1:0] == timer_pkg::MODE_HALT);
    if (tb_split) begin
      tb_enable = (tb_mode != timer_pkg::MODE_HALT);
    end else begin
      tb_enable = r.timer_b_run & (tb_mode != timer_pkg::MODE_HALT) &
        (~r.timer_mode_register[timer_pkg::TB_GATE_BIT] | pin_level[timer_pkg::PIN_TB_GATE]);
    end
    tb_tick = tb_enable & (r.timer_mode_register[timer_pkg::TB_CNT_SEL_BIT] ?
      pin_fall[timer_pkg::PIN_TB_COUNT] : mc_tick);
    tb_13 = {r.timer_b_high_count, r.timer_b_low_count[4:0]};
    tb_ovf = 1'b0;
    unique case (tb_mode)
      timer_pkg::MODE_13BIT: begin
        tb_ovf = tb_tick & (tb_13 == 13'h1fff);
        if (tb_tick) begin
          {next_r.timer_b_high_count, next_r.timer_b_low_count[4:0]} = tb_13 + 13'h0001;
        end
      end
      timer_pkg::MODE_16BIT: begin
        tb_ovf = tb_tick & ({r.timer_b_high_count, r.timer_b_low_count} == 16'hffff);
        if (tb_tick) begin
          {next_r.timer_b_high_count, next_r.timer_b_low_count} =
            {r.timer_b_high_count, r.timer_b_low_count} + 16'h0001;
        end
      end
      timer_pkg::MODE_RELOAD: begin
        tb_ovf = tb_tick & (r.timer_b_low_count == 8'hff);
        if (tb_ovf) begin
          next_r.timer_b_low_count = r.timer_b_high_count;
        end else if (tb_tick) begin
          next_r.timer_b_low_count = r.timer_b_low_count + 8'h01;
        end
      end
      timer_pkg::MODE_HALT: begin
        tb_ovf = 1'b0;
      end
    endcase
    // Third timer mode decode
    tc_run = r.timer_three_control[timer_pkg::RUN_BIT];
    tc_baud = r.timer_three_control[timer_pkg::RX_BAUD_BIT] |
      r.timer_three_control[timer_pkg::TX_BAUD_BIT];
    tc_capture = ~tc_baud & r.timer_three_control[timer_pkg::CAP_SEL_BIT];
    tc_tick = tc_run & (r.timer_three_control[timer_pkg::CNT_SEL_BIT] ?
      mc_tick : pin_fall[timer_pkg::PIN_TC_COUNT]);
    tc_count = {r.timer_c_high_count, r.timer_c_low_count};
    tc_ovf = tc_tick & (tc_count == 16'hffff);
    trig_evt = pin_fall[timer_pkg::PIN_TC_TRIG] &
      r.timer_three_control[timer_pkg::EXT_EN_BIT];
    if (tc_ovf & ~tc_capture) begin
      {next_r.timer_c_high_count, next_r.timer_c_low_count} =
        {r.capture_high_register, r.capture_low_register};
    end else if (tc_tick) begin
      {next_r.timer_c_high_count, next_r.timer_c_low_count} = tc_count + 16'h0001;
    end
    // Trigger edge: capture in capture mode, reload in reload mode
    if (trig_evt & tc_capture) begin
      next_r.capture_high_register = r.timer_c_high_count;
      next_r.capture_low_register = r.timer_c_low_count;
    end else if (trig_evt & ~tc_baud) begin
      {next_r.timer_c_high_count, next_r.timer_c_low_count} =
        {r.capture_high_register, r.capture_low_register};
    end
    // Software writes
    if (we) begin
      unique case (acc.wr_addr)
        timer_pkg::ADDR_MODE: next_r.timer_mode_register = wd;
        timer_pkg::ADDR_TB_CTRL: begin
          next_r.timer_b_run = wd[timer_pkg::TB_RUN_BIT];
          next_r.timer_b_overflow_flag = wd[timer_pkg::TB_FLAG_BIT];
        end
        timer_pkg::ADDR_TB_LOW: next_r.timer_b_low_count = wd;
        timer_pkg::ADDR_TB_HIGH: next_r.timer_b_high_count = wd;
        timer_pkg::ADDR_TC_LOW: next_r.timer_c_low_count = wd;
        timer_pkg::ADDR_TC_HIGH: next_r.timer_c_high_count = wd;
        timer_pkg::ADDR_CAP_LOW: next_r.capture_low_register = wd;
        timer_pkg::ADDR_CAP_HIGH: next_r.capture_high_register = wd;
        timer_pkg::ADDR_IRQ_STATUS: next_r.irq_status = r.irq_status & ~wd[2:0];
        timer_pkg::ADDR_IRQ_MASK: next_r.irq_mask = wd[2:0];
        timer_pkg::ADDR_SERIAL_MODE: next_r.serial_mode = wd[1:0];
        timer_pkg::ADDR_T3_CTRL: next_r.timer_three_control = wd;
        default: next_r.serial_mode = r.serial_mode;
      endcase
    end
    // Hardware flag sets; a split first timer keeps the overflow flag
    if (tb_ovf & ~tb_split) begin
      next_r.timer_b_overflow_flag = 1'b1;
      next_r.irq_status[timer_pkg::IRQ_TB_BIT] = 1'b1;
    end
    if (tc_ovf & ~tc_baud) begin
      next_r.timer_three_control[timer_pkg::T3_OVF_BIT] = 1'b1;
      next_r.irq_status[timer_pkg::IRQ_TC_OVF_BIT] = 1'b1;
    end
    if (trig_evt) begin
      next_r.timer_three_control[timer_pkg::T3_EXT_FLAG_BIT] = 1'b1;
      next_r.irq_status[timer_pkg::IRQ_TC_EXT_BIT] = 1'b1;
    end
    // Serial clocks only matter in the variable-rate serial modes
    next_r.rx_tick = r.serial_mode[0] &
      (r.timer_three_control[timer_pkg::RX_BAUD_BIT] ? tc_ovf : tb_ovf);
    next_r.tx_tick = r.serial_mode[0] &
      (r.timer_three_control[timer_pkg::TX_BAUD_BIT] ? tc_ovf : tb_ovf);
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // Outputs; the interrupt stays high while any unmasked status bit is set
  assign SERIAL_RX_TICK = r.rx_tick;
  assign SERIAL_TX_TICK = r.tx_tick;
  assign IRQ = |(r.irq_status & r.irq_mask);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  a_tb_16bit_wrap: assert property (
    tb_ovf && tb_mode == timer_pkg::MODE_16BIT && !acc.wr
    |=> r.timer_b_low_count == 8'h00 && r.timer_b_high_count == 8'h00)
    else $error("16-bit overflow did not wrap to zero");
  a_tb_reload_copy: assert property (
    tb_ovf && tb_mode == timer_pkg::MODE_RELOAD && !acc.wr
    |=> r.timer_b_low_count == $past(r.timer_b_high_count) && $stable(r.timer_b_high_count))
    else $error("8-bit reload did not copy high byte");
  a_tb_halt_hold: assert property (
    tb_mode == timer_pkg::MODE_HALT && !acc.wr
    |=> $stable(r.timer_b_low_count) && $stable(r.timer_b_high_count))
    else $error("Halted timer changed its count");
  a_tb_flag_set: assert property (
    tb_ovf && !tb_split |=> r.timer_b_overflow_flag ##1 (r.timer_b_overflow_flag || $past(acc.wr)))
    else $error("Overflow flag not set");
  a_tc_auto_reload: assert property (
    tc_ovf && !tc_capture && !acc.wr
    |=> {r.timer_c_high_count, r.timer_c_low_count} ==
      $past({r.capture_high_register, r.capture_low_register}))
    else $error("Third timer did not reload on overflow");
  a_tc_capture_copy: assert property (
    trig_evt && tc_capture && !acc.wr
    |=> {r.capture_high_register, r.capture_low_register} == $past(tc_count))
    else $error("Trigger edge did not capture count");
  a_tc_ext_flag: assert property (
    trig_evt |=> r.timer_three_control[timer_pkg::T3_EXT_FLAG_BIT]
      && r.irq_status[timer_pkg::IRQ_TC_EXT_BIT])
    else $error("Trigger edge did not set external flag");
  a_tc_off_hold: assert property (
    !tc_run && !trig_evt && !acc.wr |=> $stable(tc_count))
    else $error("Stopped third timer changed count");
  a_tc_edge_source: assert property (
    tc_run && !r.timer_three_control[timer_pkg::CNT_SEL_BIT]
      && !pin_fall[timer_pkg::PIN_TC_COUNT] && !trig_evt && !acc.wr
    |=> $stable(tc_count))
    else $error("Event counter moved without an edge");
  a_rx_baud_src: assert property (
    r.timer_three_control[timer_pkg::RX_BAUD_BIT] && r.serial_mode[0] && tc_ovf
    |=> SERIAL_RX_TICK)
    else $error("Receive clock not taken from third timer");
  a_tx_baud_src: assert property (
    !r.timer_three_control[timer_pkg::TX_BAUD_BIT] && r.serial_mode[0]
    |=> SERIAL_TX_TICK == $past(tb_ovf))
    else $error("Transmit clock not taken from second timer");
  // Split running, third timer flag, trigger reload and interrupt level
  a_tb_split_run: assert property (
    tb_split && tb_mode == timer_pkg::MODE_16BIT && mc_tick && !acc.wr
      && !r.timer_mode_register[timer_pkg::TB_CNT_SEL_BIT]
    |=> {r.timer_b_high_count, r.timer_b_low_count} ==
      $past({r.timer_b_high_count, r.timer_b_low_count}) + 16'h0001)
    else $error("Split mode did not run the second timer");
  a_tc_ovf_flag: assert property (
    tc_ovf && !tc_baud |=> r.timer_three_control[timer_pkg::T3_OVF_BIT]
      && r.irq_status[timer_pkg::IRQ_TC_OVF_BIT])
    else $error("Third timer overflow did not set its flag");
  a_tc_trig_reload: assert property (
    trig_evt && !tc_capture && !tc_baud && !acc.wr
    |=> {r.timer_c_high_count, r.timer_c_low_count} ==
      $past({r.capture_high_register, r.capture_low_register}))
    else $error("Trigger edge did not reload the count");
  a_irq_ext_level: assert property (
    r.irq_status[timer_pkg::IRQ_TC_EXT_BIT] && r.irq_mask[timer_pkg::IRQ_TC_EXT_BIT] |-> IRQ)
    else $error("External flag did not raise the interrupt");
  c_tb_reload: cover property (tb_ovf && tb_mode == timer_pkg::MODE_RELOAD);
  c_tc_capture: cover property (trig_evt && tc_capture);
  c_tc_baud: cover property (tc_ovf && tc_baud ##1 SERIAL_RX_TICK);
  c_irq_raise: cover property (!IRQ ##1 IRQ);
endmodule

// file: bench/serial_partner.sv
// Serial port stand-in that counts the baud clock pulses
`timescale 1ns/10ps
module serial_partner (
  input wire logic clk, // System clock
  input wire logic rx_tick, // Receive baud pulse
  input wire logic tx_tick, // Transmit baud pulse
  output int rx_n, // Receive pulses seen
  output int tx_n // Transmit pulses seen
);
  // Pulses stand one cycle, so one look per edge counts each once
  always @(posedge clk) begin
    if (rx_tick === 1'b1) rx_n <= rx_n + 1;
    if (tx_tick === 1'b1) tx_n <= tx_n + 1;
  end
endmodule

// file: bench/test_timer_block.sv
// Self-checking bench for the timer block
`timescale 1ns/10ps
module test_timer_block;
  logic clk = 1'b0, arst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
  logic rre = 1'b0, trig = 1'b1, cpin = 1'b1, awr, wr, bv, arr, rv, rxt, txt, irq;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, v, w;
  logic [1:0] br, rr, rs;
  int num_errors = 0, n_tests = 0, cyc = 0, rx_n, tx_n, r0, t0;
  always #5 clk = ~clk;
  timer_block timer_block_i (.REF_CLK(clk), .ARST_N(arst_n), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .TIMER_B_COUNT_PIN(1'b1), .TIMER_B_GATE_PIN(1'b1), .TIMER_C_COUNT_PIN(cpin),
    .TIMER_C_TRIGGER_PIN(trig), .SERIAL_RX_TICK(rxt), .SERIAL_TX_TICK(txt), .IRQ(irq));
  serial_partner serial_partner_i (.clk(clk), .rx_tick(rxt), .tx_tick(txt),
    .rx_n(rx_n), .tx_n(tx_n));
  // Handshakes are judged at the falling edge, where the rising edge sees them
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= {24'h0, d}; bre <= 1'b1;
    do begin
      @(negedge clk); ta = awr && awv; tw = wr && wv; tb = bv; rs = br;
      @(posedge clk); if (ta) awv <= 1'b0; if (tw) wv <= 1'b0;
    end while (!tb);
    bre <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    logic ta, tr;
    @(posedge clk);
    arv <= 1'b1; ara <= a; rre <= 1'b1;
    do begin
      @(negedge clk); ta = arr && arv; tr = rv; d = rd; rs = rr;
      @(posedge clk); if (ta) arv <= 1'b0;
    end while (!tr);
    rre <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cut a hang short; the run needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin num_errors++; test_done(); end
  end
  task automatic t_regs;
    axr(timer_pkg::ADDR_T3_CTRL, v); chk(v, 32'h0);
    axr(8'h40, v); chk({30'h0, rs}, {30'h0, timer_pkg::RESP_SLVERR});
    axw(8'h40, 8'h11); chk({30'h0, rs}, {30'h0, timer_pkg::RESP_SLVERR});
    $display("done regs");
  endtask
  task automatic t_reload;
    axw(timer_pkg::ADDR_IRQ_MASK, 8'h01); axw(timer_pkg::ADDR_TB_HIGH, 8'hfd);
    axw(timer_pkg::ADDR_TB_LOW, 8'hfd); axw(timer_pkg::ADDR_MODE, 8'h20);
    axw(timer_pkg::ADDR_TB_CTRL, 8'h01);
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    axr(timer_pkg::ADDR_TB_LOW, v); chk(v, 32'hfd);
    axr(timer_pkg::ADDR_TB_HIGH, v); chk(v, 32'hfd);
    axw(timer_pkg::ADDR_IRQ_STATUS, 8'h01); @(negedge clk); chk({31'h0, irq}, 32'h0);
    $display("done reload");
  endtask
  task automatic t_halt;
    axw(timer_pkg::ADDR_MODE, 8'h30); axr(timer_pkg::ADDR_TB_LOW, v);
    repeat (50) @(posedge clk);
    axr(timer_pkg::ADDR_TB_LOW, w); chk(w, v);
    // Split first timer: run is ignored, the mode field alone starts and stops
    axw(timer_pkg::ADDR_TB_CTRL, 8'h00); axw(timer_pkg::ADDR_MODE, 8'h13);
    axr(timer_pkg::ADDR_TB_LOW, v);
    repeat (50) @(posedge clk);
    axr(timer_pkg::ADDR_TB_LOW, w); chk({31'h0, w !== v}, 32'h1);
    axw(timer_pkg::ADDR_MODE, 8'h33); axr(timer_pkg::ADDR_TB_LOW, v);
    repeat (50) @(posedge clk);
    axr(timer_pkg::ADDR_TB_LOW, w); chk(w, v);
    $display("done halt");
  endtask
  task automatic t_capture;
    axw(timer_pkg::ADDR_IRQ_MASK, 8'h04); axw(timer_pkg::ADDR_T3_CTRL, 8'h0f);
    @(posedge clk); trig <= 1'b0;
    repeat (10) @(posedge clk);
    axr(timer_pkg::ADDR_T3_CTRL, v); chk(v, 32'h4f);
    chk({31'h0, irq}, 32'h1); trig <= 1'b1;
    $display("done capture");
  endtask
  task automatic t_baud;
    axw(timer_pkg::ADDR_IRQ_MASK, 8'h00); axw(timer_pkg::ADDR_CAP_LOW, 8'hfe);
    axw(timer_pkg::ADDR_CAP_HIGH, 8'hff); axw(timer_pkg::ADDR_SERIAL_MODE, 8'h01);
    axw(timer_pkg::ADDR_T3_CTRL, 8'h17);
    // Preload the count after the mode change, so every overflow reloads
    axw(timer_pkg::ADDR_TC_HIGH, 8'hff); axw(timer_pkg::ADDR_TC_LOW, 8'hfe);
    r0 = rx_n; t0 = tx_n;
    // Reload 0xfffe gives one overflow every two machine cycles
    repeat (240) @(posedge clk);
    chk({31'h0, (tx_n - t0) >= 9 && (tx_n - t0) <= 11}, 32'h1);
    chk(rx_n - r0, 32'h0);
    axw(timer_pkg::ADDR_T3_CTRL, 8'h37); r0 = rx_n;
    repeat (240) @(posedge clk);
    chk({31'h0, (rx_n - r0) >= 9 && (rx_n - r0) <= 11}, 32'h1);
    $display("done baud");
  endtask
  task automatic t_edge;
    // Edge counting in reload mode; three falls carry 0xfffd through an overflow
    axw(timer_pkg::ADDR_T3_CTRL, 8'h04); axw(timer_pkg::ADDR_TC_LOW, 8'hfd);
    axw(timer_pkg::ADDR_TC_HIGH, 8'hff);
    repeat (3) begin
      cpin <= 1'b0;
      repeat (4) @(posedge clk);
      cpin <= 1'b1;
      repeat (4) @(posedge clk);
    end
    axr(timer_pkg::ADDR_TC_LOW, v); chk(v, 32'hfe);
    axr(timer_pkg::ADDR_T3_CTRL, v); chk(v, 32'h84);
    axw(timer_pkg::ADDR_T3_CTRL, 8'h0c); axw(timer_pkg::ADDR_TC_LOW, 8'h00);
    trig <= 1'b0;
    repeat (6) @(posedge clk);
    trig <= 1'b1;
    axr(timer_pkg::ADDR_TC_LOW, v); chk(v, 32'hfe);
    axr(timer_pkg::ADDR_T3_CTRL, v); chk(v, 32'h4c);
    $display("done edge");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs(); t_reload(); t_halt(); t_capture(); t_baud(); t_edge();
    test_done();
  end
endmodule
